// ===== hdl/sbr_pkg.sv
// Purpose: Shared constants for the standby release and reset block
// Assumes: One system clock, AHB-Lite register access
// Notes:   Offsets are byte addresses of 32-bit words
`default_nettype none
package sbr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_ACC    = 8'h04;
    localparam logic [7:0] OFS_PORT   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_DMEM   = 8'h10;
    localparam int         ADDR_W     = 8;
    // Command register bit positions
    localparam int CMD_STOP  = 0;
    localparam int CMD_HALT  = 1;
    localparam int CMD_FLAG_TEST = 2;
    localparam int CMD_TIMER     = 3;
    localparam int CMD_LOAD_ENA  = 4;
    localparam int CMD_LOAD_PSEL = 5;
    // Accumulator fields used by port-output instruction
    localparam int ACC_ENA_BIT = 3;
    localparam int ACC_PSEL_LO = 1;
    // Port register fields
    localparam int PORT_OE_LO = 4;
    // Status register fields
    localparam int ST_MODE_LO = 0;
    localparam int ST_TFLAG   = 2;
    localparam int ST_EFLAG   = 3;
    localparam int ST_ENA     = 4;
    localparam int ST_PSEL_LO = 5;
    localparam int ST_CNT_LO  = 8;
    localparam int ST_PC_LO   = 16;
    // Widths and reset values
    localparam int         PC_W      = 10;
    localparam int         CNT_W     = 8;
    localparam int         PRE_W     = 8;
    localparam logic [9:0] PC_RST    = 10'h000;
    localparam logic [7:0] CNT_RST   = 8'h00;
    localparam logic [7:0] PRE_RST   = 8'h00;
    localparam logic [1:0] PSEL_RST  = 2'h0;
    localparam logic [7:0] CNT_MAX   = 8'hff;
    // Prescaler tap masks: divide by 4, 32, 256
    localparam logic [7:0] TAP_DIV4   = 8'h03;
    localparam logic [7:0] TAP_DIV32  = 8'h1f;
    localparam logic [7:0] TAP_DIV256 = 8'hff;
    // Count pulse select encodings
    localparam logic [1:0] PSEL_DIV256 = 2'h0;
    localparam logic [1:0] PSEL_EXT    = 2'h1;
    localparam logic [1:0] PSEL_DIV32  = 2'h2;
    localparam logic [1:0] PSEL_DIV4   = 2'h3;
    // Operating modes
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_HALT  = 2'b01,
        MODE_STOP  = 2'b10,
        MODE_RESET = 2'b11
    } sbr_mode_t;
endpackage : sbr_pkg
`default_nettype wire

// ===== hdl/sbr_tmr_if.sv
// Purpose: Carrier between the controller and the timer/event counter
// Assumes: Same clock on both sides
// Notes:   ctl drives controls, tmr answers with count and overflow
`default_nettype none
interface sbr_tmr_if;
    logic       clear_all;
    logic       clear_cnt;
    logic       run;
    logic [1:0] psel;
    logic       ev_edge;
    logic [7:0] count;
    logic       ovf;
    modport ctl (output clear_all, clear_cnt, run, psel, ev_edge, input count, ovf);
    modport tmr (input clear_all, clear_cnt, run, psel, ev_edge, output count, ovf);
endinterface : sbr_tmr_if
`default_nettype wire

// ===== hdl/sbr_timer.sv
// Purpose: Prescalers and 8-bit timer/event count register
// Assumes: Event edge already synchronised
// Notes:   Overflow is a one-cycle pulse on the wrap from ff to 00
`default_nettype none
module sbr_timer (
    // Clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RESET_N,
    // Controller side
    sbr_tmr_if.tmr    tif
);
    logic [7:0] pre_ff;
    logic [7:0] cnt_ff;
    logic       ovf_ff;
    logic       tick;
    logic       tap4;
    logic       tap32;
    logic       tap256;
    logic       wrap;

    assign tap4   = (pre_ff & sbr_pkg::TAP_DIV4) == sbr_pkg::TAP_DIV4;
    assign tap32  = (pre_ff & sbr_pkg::TAP_DIV32) == sbr_pkg::TAP_DIV32;
    assign tap256 = (pre_ff & sbr_pkg::TAP_DIV256) == sbr_pkg::TAP_DIV256;
    // Pulse source select
    assign tick = tif.run && (
                  (tif.psel == sbr_pkg::PSEL_DIV256) ? tap256 :
                  (tif.psel == sbr_pkg::PSEL_EXT)    ? tif.ev_edge :
                  (tif.psel == sbr_pkg::PSEL_DIV32)  ? tap32 : tap4);
    assign wrap = tick && (cnt_ff == sbr_pkg::CNT_MAX) && !tif.clear_cnt;
    assign tif.count = cnt_ff;
    assign tif.ovf   = ovf_ff;

    // Three prescaler stages in one chain
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pre_ff <= sbr_pkg::PRE_RST;
        end else if (tif.clear_all) begin
            pre_ff <= sbr_pkg::PRE_RST;
        end else if (tif.run) begin
            pre_ff <= pre_ff + 8'h01;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_ff <= sbr_pkg::CNT_RST;
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= wrap && !tif.clear_all;
            if (tif.clear_all || tif.clear_cnt) begin
                cnt_ff <= sbr_pkg::CNT_RST;
            end else if (tick) begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end
endmodule : sbr_timer
`default_nettype wire

// ===== hdl/sbr_top.sv
// Purpose: Standby release and reset initialisation of a 4-bit controller
// Assumes: AHB-Lite master issues single word transfers
// Notes:   Chip reset pin is active high and synchronised to SYS_CLK
// Behaviour
// - Stop mode ignores request flags; only chip reset ends it.
// - Any set request flag ends halt, execution resumes after halt.
// - Leaving halt by flag keeps registers and data memory unchanged.
// - Reset high keeps halt; reset low leaves halt, resets, starts at 0.
// - Reset ending halt keeps data memory, registers count as undefined.
// - Chip reset input is active high and initialises the chip.
// - Reset clears the ten-bit program counter.
// - Reset clears both skip flags.
// - Reset clears the eight-bit count register.
// - Reset clears pulse select, giving system clock divided by 256.
// - Reset clears the three prescaler stages.
// - Reset clears the external test enable flag.
// - Reset clears both request flags.
// - Reset outside standby leaves memory, accumulator, ports latches undefined.
// - Reset turns off port drivers and sets ports to input.
// - Reset leaving either standby keeps data memory contents.
// - After reset the first fetch is from address zero.
// - Port output with selector fifteen loads test enable from accumulator bit 3.
// - Test input rising edge sets its flag; counter wrap sets timer flag.
// - Reset during stop enters halt and restarts oscillator.
// - In halt only CPU clock stops; timer keeps counting.
`default_nettype none
module sbr_top (
    // Clock and system reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    // Device pins
    input  wire logic        CHIP_RESET,
    input  wire logic        EXTERNAL_TEST_INPUT,
    input  wire logic        EVENT_INPUT,
    // Port pins and clock controls
    output logic [3:0]       PORT_OUT,
    output logic [3:0]       PORT_OE,
    output logic             CPU_CLOCK_ENABLE,
    output logic             OSC_ENABLE,
    output logic [9:0]       PROGRAM_COUNTER
);
    localparam int NSYNC = 3;

    sbr_tmr_if tif ();

    sbr_pkg::sbr_mode_t mode_ff;
    sbr_pkg::sbr_mode_t nxt_mode;
    logic [NSYNC-1:0] sync_a_ff;
    logic [NSYNC-1:0] sync_b_ff;
    logic [NSYNC-1:0] pins;
    logic [1:0]       edge_prev_ff;
    logic [9:0]       pc_ff;
    logic [9:0]       nxt_pc;
    logic [1:0]       skip_ff;
    logic             tflag_ff;
    logic             eflag_ff;
    logic             ena_ff;
    logic [1:0]       psel_ff;
    logic [3:0]       acc_ff;
    logic [3:0]       lat_ff;
    logic [3:0]       oe_ff;
    logic [3:0]       dmem_ff;
    logic             rst_seen_ff;
    logic             wr_pend_ff;
    logic [7:0]       wr_addr_ff;
    logic [31:0]      rdata_ff;
    logic             crst;
    logic             test_edge;
    logic             ev_edge;
    logic             any_flag;
    logic             addr_phase;
    logic             wr_cmd;
    logic             wr_acc;
    logic             wr_port;
    logic             wr_dmem;
    logic             cpu_run;
    logic             cmd_stop;
    logic             cmd_halt;
    logic             cmd_flag_test;
    logic             cmd_timer;
    logic             cmd_load_ena;
    logic             cmd_load_psel;
    logic [31:0]      status_word;
    logic [31:0]      rd_mux;

    // Two-stage synchronisers on pins
    assign pins = {EVENT_INPUT, EXTERNAL_TEST_INPUT, CHIP_RESET};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge SYS_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    sync_a_ff[gi] <= 1'b0;
                    sync_b_ff[gi] <= 1'b0;
                end else begin
                    sync_a_ff[gi] <= pins[gi];
                    sync_b_ff[gi] <= sync_a_ff[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            edge_prev_ff <= 2'h0;
        end else begin
            edge_prev_ff <= sync_b_ff[2:1];
        end
    end

    assign crst      = sync_b_ff[0];
    assign test_edge = sync_b_ff[1] && !edge_prev_ff[0] && ena_ff;
    assign ev_edge   = sync_b_ff[2] && !edge_prev_ff[1];
    assign any_flag  = tflag_ff || eflag_ff;

    // Bus decode
    assign addr_phase = HSEL && HTRANS[1] && HREADY;
    assign wr_cmd  = wr_pend_ff && (wr_addr_ff == sbr_pkg::OFS_CMD);
    assign wr_acc  = wr_pend_ff && (wr_addr_ff == sbr_pkg::OFS_ACC);
    assign wr_port = wr_pend_ff && (wr_addr_ff == sbr_pkg::OFS_PORT);
    assign wr_dmem = wr_pend_ff && (wr_addr_ff == sbr_pkg::OFS_DMEM);
    assign cpu_run = (mode_ff == sbr_pkg::MODE_RUN) && !crst;
    // Instructions only execute while the CPU clock runs
    assign cmd_stop  = wr_cmd && cpu_run && HWDATA[sbr_pkg::CMD_STOP];
    assign cmd_halt  = wr_cmd && cpu_run && HWDATA[sbr_pkg::CMD_HALT];
    assign cmd_flag_test = wr_cmd && cpu_run && HWDATA[sbr_pkg::CMD_FLAG_TEST];
    assign cmd_timer     = wr_cmd && cpu_run && HWDATA[sbr_pkg::CMD_TIMER];
    assign cmd_load_ena  = wr_cmd && cpu_run && HWDATA[sbr_pkg::CMD_LOAD_ENA];
    assign cmd_load_psel = wr_cmd && cpu_run && HWDATA[sbr_pkg::CMD_LOAD_PSEL];

    assign status_word = {6'h00, pc_ff, tif.count, 1'b0, psel_ff, ena_ff,
                          eflag_ff, tflag_ff, mode_ff};
    assign rd_mux = (HADDR[7:0] == sbr_pkg::OFS_ACC)    ? {28'h0, acc_ff} :
                    (HADDR[7:0] == sbr_pkg::OFS_PORT)   ? {24'h0, oe_ff, lat_ff} :
                    (HADDR[7:0] == sbr_pkg::OFS_STATUS) ? status_word :
                    (HADDR[7:0] == sbr_pkg::OFS_DMEM)   ? {28'h0, dmem_ff} : 32'h0;

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_ff;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff   <= 32'h0;
        end else begin
            wr_pend_ff <= addr_phase && HWRITE;
            if (addr_phase) begin
                wr_addr_ff <= HADDR[7:0];
                rdata_ff   <= HWRITE ? 32'h0 : rd_mux;
            end
        end
    end

    // Mode sequencing
    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            sbr_pkg::MODE_RUN: begin
                if (crst) begin
                    nxt_mode = sbr_pkg::MODE_RESET;
                end else if (cmd_stop && !any_flag) begin
                    nxt_mode = sbr_pkg::MODE_STOP;
                end else if (cmd_halt && !any_flag) begin
                    nxt_mode = sbr_pkg::MODE_HALT;
                end
            end
            sbr_pkg::MODE_HALT: begin
                if (crst) begin
                    nxt_mode = sbr_pkg::MODE_HALT;
                end else if (rst_seen_ff || any_flag) begin
                    nxt_mode = sbr_pkg::MODE_RUN;
                end
            end
            sbr_pkg::MODE_STOP: begin
                if (crst) begin
                    nxt_mode = sbr_pkg::MODE_HALT;
                end
            end
            sbr_pkg::MODE_RESET: begin
                if (!crst) begin
                    nxt_mode = sbr_pkg::MODE_RUN;
                end
            end
            default: nxt_mode = sbr_pkg::MODE_RESET;
        endcase
    end

    // Program counter: held in standby, zero under reset
    assign nxt_pc = crst ? sbr_pkg::PC_RST :
                    (rst_seen_ff ? sbr_pkg::PC_RST :
                    (cpu_run && !cmd_stop && !cmd_halt ? pc_ff + 10'h001 : pc_ff));

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_ff     <= sbr_pkg::MODE_RESET;
            pc_ff       <= sbr_pkg::PC_RST;
            rst_seen_ff <= 1'b0;
        end else begin
            mode_ff     <= nxt_mode;
            pc_ff       <= nxt_pc;
            rst_seen_ff <= crst;
        end
    end

    // Flags, enable, pulse select and skip flags
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tflag_ff <= 1'b0;
            eflag_ff <= 1'b0;
            ena_ff   <= 1'b0;
            psel_ff  <= sbr_pkg::PSEL_RST;
            skip_ff  <= 2'h0;
        end else if (crst) begin
            tflag_ff <= 1'b0;
            eflag_ff <= 1'b0;
            ena_ff   <= 1'b0;
            psel_ff  <= sbr_pkg::PSEL_RST;
            skip_ff  <= 2'h0;
        end else begin
            // Set wins over the clear of the same cycle
            tflag_ff <= (tflag_ff && !cmd_flag_test && !cmd_timer) || tif.ovf;
            eflag_ff <= (eflag_ff && !cmd_flag_test) || test_edge;
            if (cmd_load_ena) begin
                ena_ff <= acc_ff[sbr_pkg::ACC_ENA_BIT];
            end
            if (cmd_load_psel) begin
                psel_ff <= acc_ff[sbr_pkg::ACC_PSEL_LO +: 2];
            end
            skip_ff <= cmd_flag_test ? {1'b0, any_flag} : skip_ff;
        end
    end

    // Accumulator, port latches and data memory are not touched by chip reset
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_ff  <= 4'h0;
            lat_ff  <= 4'h0;
            dmem_ff <= 4'h0;
        end else begin
            if (wr_acc) begin
                acc_ff <= HWDATA[3:0];
            end
            if (wr_port) begin
                lat_ff <= HWDATA[3:0];
            end
            if (wr_dmem) begin
                dmem_ff <= HWDATA[3:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            oe_ff <= 4'h0;
        end else if (crst) begin
            oe_ff <= 4'h0;
        end else if (wr_port) begin
            oe_ff <= HWDATA[sbr_pkg::PORT_OE_LO +: 4];
        end
    end

    // Timer keeps counting in halt, frozen in stop
    assign tif.clear_all = crst;
    assign tif.clear_cnt = cmd_timer;
    assign tif.run       = (mode_ff != sbr_pkg::MODE_STOP);
    assign tif.psel      = psel_ff;
    assign tif.ev_edge   = ev_edge;

    sbr_timer u_timer (
        .SYS_CLK (SYS_CLK),
        .RESET_N (RESET_N),
        .tif     (tif)
    );

    assign PORT_OUT         = lat_ff;
    assign PORT_OE          = oe_ff;
    assign CPU_CLOCK_ENABLE = (mode_ff == sbr_pkg::MODE_RUN);
    assign OSC_ENABLE       = (mode_ff != sbr_pkg::MODE_STOP);
    assign PROGRAM_COUNTER  = pc_ff;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    a_stop_holds_flag: assert property (
        (mode_ff == sbr_pkg::MODE_STOP) && !crst |=> mode_ff == sbr_pkg::MODE_STOP)
        else $error("Stop mode left without reset");
    a_halt_flag_release: assert property (
        (mode_ff == sbr_pkg::MODE_HALT) && !crst && any_flag
        |=> mode_ff == sbr_pkg::MODE_RUN)
        else $error("Halt not released by request flag");
    a_halt_keeps_pc: assert property (
        (mode_ff == sbr_pkg::MODE_HALT) && !crst && !rst_seen_ff |=> $stable(pc_ff))
        else $error("Program counter changed across halt release");
    a_reset_holds_halt: assert property (
        (mode_ff == sbr_pkg::MODE_HALT) && crst ##1 crst
        |-> mode_ff == sbr_pkg::MODE_HALT)
        else $error("Halt left while reset high");
    a_reset_init_state: assert property (
        crst |=> pc_ff == 10'h000 && skip_ff == 2'h0 && !ena_ff && psel_ff == 2'h0)
        else $error("Reset did not initialise counter and flags");
    a_reset_clears_flags: assert property (
        crst |=> !tflag_ff && !eflag_ff)
        else $error("Reset did not clear request flags");
    a_reset_clears_count: assert property (
        crst ##1 crst |=> tif.count == 8'h00)
        else $error("Reset did not clear count register");
    a_port_drivers_off: assert property (
        crst |=> oe_ff == 4'h0)
        else $error("Port drivers on during reset");
    a_dmem_retained: assert property (
        crst && !wr_dmem |=> $stable(dmem_ff))
        else $error("Data memory changed during reset");
    a_stop_to_halt: assert property (
        (mode_ff == sbr_pkg::MODE_STOP) && crst |=> mode_ff == sbr_pkg::MODE_HALT && OSC_ENABLE)
        else $error("Reset in stop did not enter halt");
    a_first_fetch_zero: assert property (
        $fell(crst) |=> mode_ff == sbr_pkg::MODE_RUN && pc_ff == 10'h000)
        else $error("Execution did not restart at zero");
    a_refuse_standby: assert property (
        cpu_run && (cmd_stop || cmd_halt) && any_flag |=> mode_ff == sbr_pkg::MODE_RUN)
        else $error("Standby entered with request flag set");
endmodule : sbr_top
`default_nettype wire

// ===== dv/sbr_pin_model.sv
// Purpose: Far-side pins: chip reset source, test input and event pulses
// Assumes: Bench raises requests right after a rising edge
// Notes:   Event pin rests low when idle, as with a pull-down
`default_nettype none
module sbr_pin_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Requests from bench
    input  wire logic reset_req,
    input  wire logic test_req,
    input  wire logic event_req,
    // Device pins
    output logic      chip_reset,
    output logic      test_pin,
    output logic      event_pin
);
    logic [2:0] test_cnt_ff;
    logic [1:0] ev_div_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_reset  <= 1'b0;
            test_cnt_ff <= 3'h0;
            ev_div_ff   <= 2'h0;
        end else begin
            chip_reset  <= reset_req;
            test_cnt_ff <= test_req ? 3'h5 : test_cnt_ff - {2'h0, |test_cnt_ff};
            ev_div_ff   <= event_req ? ev_div_ff + 2'h1 : 2'h0;
        end
    end
    // Test pin: one clean rising edge per request, then low; event pin toggles every two cycles while requested
    assign test_pin  = |test_cnt_ff;
    assign event_pin = ev_div_ff[1];
endmodule : sbr_pin_model
`default_nettype wire

// ===== dv/test_standby_release_and_reset_init.sv
// Purpose: Self-checking bench for standby release and reset
// Assumes: Zero-wait AHB-Lite slave, pins driven through the pin model
// Notes:   Undefined registers are expected to keep their old values
`default_nettype none
module test_standby_release_and_reset_init;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 20000;
    logic        SYS_CLK, rst_n, hsel, hwrite, hready, reset_req, test_req, event_req;
    logic        chip_reset, test_pin, event_pin, cpu_en, osc_en, hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [3:0]  port_out, port_oe;
    logic [9:0]  pc, pc_h, pc_a;
    int          err_count, compares, cycles;

    sbr_top dut_u (.SYS_CLK(SYS_CLK), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .CHIP_RESET(chip_reset),
        .EXTERNAL_TEST_INPUT(test_pin), .EVENT_INPUT(event_pin), .PORT_OUT(port_out),
        .PORT_OE(port_oe), .CPU_CLOCK_ENABLE(cpu_en), .OSC_ENABLE(osc_en),
        .PROGRAM_COUNTER(pc));
    sbr_pin_model pin_u (.clk(SYS_CLK), .rst_n(rst_n), .reset_req(reset_req),
        .test_req(test_req), .event_req(event_req), .chip_reset(chip_reset),
        .test_pin(test_pin), .event_pin(event_pin));

    always #25 SYS_CLK = ~SYS_CLK;

    // Counter value the status read sees at its address phase
    always @(posedge SYS_CLK) begin
        if (hsel && htrans[1]) begin
            pc_a <= pc;
        end
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge SYS_CLK);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge SYS_CLK); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge SYS_CLK); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd_chk

    // Status bits: pulse select, enable, test flag, timer flag, mode
    task automatic chk_st(input logic [6:0] e);
        logic [31:0] r;
        ahb(1'b0, sbr_pkg::OFS_STATUS, 32'h0, r);
        chk({25'h0, r[6:0]}, {25'h0, e});
    endtask : chk_st

    task automatic chk_sw(input logic [15:0] e);
        logic [31:0] r;
        ahb(1'b0, sbr_pkg::OFS_STATUS, 32'h0, r);
        chk(r, {6'h0, pc_a, e});
    endtask : chk_sw

    task automatic cmd(input int bitpos);
        wr(sbr_pkg::OFS_CMD, 32'h1 << bitpos);
    endtask : cmd

    task automatic pulse();
        @(posedge SYS_CLK);
        test_req <= 1'b1;
        @(posedge SYS_CLK);
        test_req <= 1'b0;
    endtask : pulse

    task automatic wait_run(input int lim);
        int n;
        n = 0;
        while (cpu_en !== 1'b1 && n < lim) begin
            @(posedge SYS_CLK);
            n++;
        end
        chk({31'h0, cpu_en}, 32'h1);
    endtask : wait_run

    initial begin
        SYS_CLK = 1'b0;
        rst_n = 1'b0;
        {hsel, hwrite, reset_req, test_req, event_req} = 5'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        {err_count, compares, cycles} = '0;
        repeat (3) @(posedge SYS_CLK);
        rst_n <= 1'b1;
        chk_st({2'h0, 3'h0, sbr_pkg::MODE_RUN});
        chk_sw(16'h0000);
        chk({28'h0, port_oe}, 32'h0);
        wr(8'h20, 32'h5);
        rd_chk(8'h20, 32'h0);
        rd_chk(sbr_pkg::OFS_CMD, 32'h0);
        // Test input ignored while disabled
        pulse();
        repeat (10) @(posedge SYS_CLK);
        chk_st({2'h0, 3'h0, sbr_pkg::MODE_RUN});
        // Enable, set flag, standby refused
        wr(sbr_pkg::OFS_ACC, 32'h8);
        cmd(sbr_pkg::CMD_LOAD_ENA);
        pulse();
        repeat (10) @(posedge SYS_CLK);
        chk_st({2'h0, 3'b110, sbr_pkg::MODE_RUN});
        cmd(sbr_pkg::CMD_HALT);
        chk_st({2'h0, 3'b110, sbr_pkg::MODE_RUN});
        cmd(sbr_pkg::CMD_STOP);
        chk_st({2'h0, 3'b110, sbr_pkg::MODE_RUN});
        cmd(sbr_pkg::CMD_FLAG_TEST);
        // Halt released by test flag
        wr(sbr_pkg::OFS_DMEM, 32'h5);
        wr(sbr_pkg::OFS_PORT, 32'hf3);
        cmd(sbr_pkg::CMD_HALT);
        chk_st({2'h0, 3'b100, sbr_pkg::MODE_HALT});
        pc_h = pc;
        pulse();
        wait_run(20);
        chk({22'h0, pc}, {22'h0, pc_h});
        rd_chk(sbr_pkg::OFS_DMEM, 32'h5);
        rd_chk(sbr_pkg::OFS_ACC, 32'h8);
        rd_chk(sbr_pkg::OFS_PORT, 32'hf3);
        chk({23'h0, hresp, port_oe, port_out}, 32'hf3);
        cmd(sbr_pkg::CMD_FLAG_TEST);
        // Event pulses count on in halt until wrap
        wr(sbr_pkg::OFS_ACC, 32'h2);
        cmd(sbr_pkg::CMD_LOAD_PSEL);
        cmd(sbr_pkg::CMD_TIMER);
        event_req <= 1'b1;
        cmd(sbr_pkg::CMD_HALT);
        chk_st({sbr_pkg::PSEL_EXT, 3'b100, sbr_pkg::MODE_HALT});
        wait_run(1500);
        event_req <= 1'b0;
        chk_st({sbr_pkg::PSEL_EXT, 3'b101, sbr_pkg::MODE_RUN});
        cmd(sbr_pkg::CMD_FLAG_TEST);
        // Stop ends only through chip reset
        cmd(sbr_pkg::CMD_STOP);
        @(posedge SYS_CLK);
        chk({31'h0, osc_en}, 32'h0);
        pulse();
        repeat (10) @(posedge SYS_CLK);
        chk_st({sbr_pkg::PSEL_EXT, 3'b110, sbr_pkg::MODE_STOP});
        reset_req <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        chk_st({2'h0, 3'h0, sbr_pkg::MODE_HALT});
        chk({31'h0, osc_en}, 32'h1);
        chk({18'h0, port_oe, pc}, 32'h0);
        reset_req <= 1'b0;
        wait_run(20);
        chk({22'h0, pc}, 32'h0);
        rd_chk(sbr_pkg::OFS_DMEM, 32'h5);
        chk_st({2'h0, 3'h0, sbr_pkg::MODE_RUN});
        // Halt ended by chip reset
        wr(sbr_pkg::OFS_DMEM, 32'ha);
        cmd(sbr_pkg::CMD_HALT);
        reset_req <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        chk_st({2'h0, 3'h0, sbr_pkg::MODE_HALT});
        reset_req <= 1'b0;
        wait_run(20);
        chk({22'h0, pc}, 32'h0);
        rd_chk(sbr_pkg::OFS_DMEM, 32'ha);
        // Reset outside standby
        reset_req <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        chk_st({2'h0, 3'h0, sbr_pkg::MODE_RESET});
        reset_req <= 1'b0;
        wait_run(20);
        chk({22'h0, pc}, 32'h0);
        repeat (200) @(posedge SYS_CLK);
        chk_sw(16'h0000);
        rd_chk(sbr_pkg::OFS_DMEM, 32'ha);
        finish_test();
    end
endmodule : test_standby_release_and_reset_init
`default_nettype wire
